// ===== shared/pwr_boot_pkg.sv
package pwr_boot_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
   localparam logic [7:0] ADDR_HOST_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_BOOT_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CTRL    = 8'h0C;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int SLEEP_LSB    = 10;
   localparam int SLEEP_MSB    = 15;
   localparam int DOORBELL_BIT = 1;
   localparam int GIE_BIT      = 0;
   localparam int NONMASK_IRQ_ENABLE_BIT     = 1;

   // ----------------------------------------
   // Sleep codes and reset values
   // ----------------------------------------
   localparam logic [5:0] SLEEP_NONE     = 6'h00;
   localparam logic [5:0] SLEEP_GATE_EN  = 6'h09;
   localparam logic [5:0] SLEEP_GATE_ANY = 6'h11;
   localparam logic [5:0] SLEEP_PLL_OUT  = 6'h1A;
   localparam logic [5:0] SLEEP_PLL_IN   = 6'h1C;
   localparam logic [5:0] SLEEP_RST      = 6'h00;

   // ----------------------------------------
   // Timing and ROM size
   // ----------------------------------------
   localparam int SLEEP_DELAY_CYC = 9;
   localparam int ROM_BYTES       = 1024;
   localparam int ROM_WORDS       = ROM_BYTES / 4;

   typedef enum logic [1:0] {
      BOOT_HOST = 2'h0,
      BOOT_EMU  = 2'h1,
      BOOT_ROM  = 2'h2
   } boot_mode_t;

   typedef enum logic [1:0] {
      ROM_W8  = 2'h0,
      ROM_W16 = 2'h1,
      ROM_W32 = 2'h2
   } rom_width_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        req;
      logic [31:0] addr;
   } rom_rd_t;

   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [31:0] data;
   } mem_wr_t;

endpackage : pwr_boot_pkg

// ===== logic/pwr_boot_ctrl.sv
`timescale 1ns/1ns
module pwr_boot_ctrl #(
   parameter int ROM_WORDS_P = pwr_boot_pkg::ROM_WORDS
) (
   input  wire logic                     clk_sys_i,
   input  wire logic                     rstn_i,
   input  wire pwr_boot_pkg::apb_req_t   apb_i,
   output logic                          pready_o,
   output logic                          pslverr_o,
   output logic [31:0]                   prdata_o,
   input  wire pwr_boot_pkg::boot_mode_t boot_mode_i,
   input  wire pwr_boot_pkg::rom_width_t rom_width_i,
   input  wire logic                     trst_i,
   input  wire logic [1:0]               debug_config_pins_i,
   input  wire logic                     irq_pending_i,
   input  wire logic                     irq_enabled_i,
   input  wire logic                     pll_lock_i,
   output logic                          cpu_clk_en_o,
   output logic                          pll_out_stop_o,
   output logic                          pll_in_stop_o,
   output logic                          io_freeze_o,
   output logic                          cpu_stall_o,
   output logic                          run_isr_o,
   output logic                          resume_pulse_o,
   output logic [1:0]                    debug_mode_o,
   output logic                          debug_mode_vld_o,
   output pwr_boot_pkg::rom_rd_t         rom_rd_o,
   input  wire logic                     rom_rvalid_i,
   input  wire logic [31:0]              rom_rdata_i,
   output pwr_boot_pkg::mem_wr_t         mem_wr_o
);
   import pwr_boot_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [2:0] trst_sync_r;
   logic [1:0] dbg_s1_r;
   logic [1:0] dbg_s2_r;
   logic [1:0] irq_s1_r;
   logic [1:0] irq_s2_r;
   logic [1:0] lock_sync_r;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trst_sync_r <= 3'h0;
         dbg_s1_r    <= 2'h0;
         dbg_s2_r    <= 2'h0;
         irq_s1_r    <= 2'h0;
         irq_s2_r    <= 2'h0;
         lock_sync_r <= 2'h0;
      end else begin
         trst_sync_r <= {trst_sync_r[1:0], trst_i};
         dbg_s1_r    <= debug_config_pins_i;
         dbg_s2_r    <= dbg_s1_r;
         irq_s1_r    <= {irq_enabled_i, irq_pending_i};
         irq_s2_r    <= irq_s1_r;
         lock_sync_r <= {lock_sync_r[0], pll_lock_i};
      end
   end

   // ----------------------------------------
   // Debug configuration latch
   // ----------------------------------------
   // latch on rise
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         debug_mode_o     <= 2'h0;
         debug_mode_vld_o <= 1'b0;
      end else if (trst_sync_r[1] && !trst_sync_r[2]) begin
         debug_mode_o     <= dbg_s2_r;
         debug_mode_vld_o <= 1'b1;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [5:0] sleep_sel_r;
   logic       doorbell_r;
   logic [1:0] irq_ctrl_r;
   logic       wr_en;
   logic       rd_en;
   logic       db_set;
   logic       db_clr;
   logic       stall_r;
   logic       copy_busy_r;
   logic       boot_done_r;
   logic       sleep_gate_r;
   logic       sleep_exit;

   assign wr_en     = apb_i.psel && apb_i.penable && apb_i.pwrite;
   assign rd_en     = apb_i.psel && !apb_i.penable && !apb_i.pwrite;
   assign pready_o  = 1'b1;
   assign pslverr_o = 1'b0;

   assign db_set = wr_en && apb_i.paddr == ADDR_HOST_CTRL
                   && apb_i.pwdata[DOORBELL_BIT];
   assign db_clr = wr_en && apb_i.paddr == ADDR_CTRL_STATUS
                   && !apb_i.pwdata[DOORBELL_BIT];

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sleep_sel_r <= SLEEP_RST;
      end else if (sleep_exit) begin
         sleep_sel_r <= SLEEP_NONE;
      end else if (wr_en && apb_i.paddr == ADDR_CTRL_STATUS) begin
         sleep_sel_r <= apb_i.pwdata[SLEEP_MSB:SLEEP_LSB];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_ctrl_r <= 2'h0;
      end else if (wr_en && apb_i.paddr == ADDR_IRQ_CTRL) begin
         irq_ctrl_r <= apb_i.pwdata[1:0];
      end
   end

   // clear blocked while stalled; set wins over clear
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         doorbell_r <= 1'b0;
      end else if (db_set) begin
         doorbell_r <= 1'b1;
      end else if (db_clr && !stall_r) begin
         doorbell_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_o <= 32'h0;
      end else if (rd_en) begin
         case (apb_i.paddr)
            ADDR_CTRL_STATUS:
               prdata_o <= {16'h0, sleep_sel_r, 10'h0};
            ADDR_HOST_CTRL:
               prdata_o <= {30'h0, doorbell_r, 1'b0};
            ADDR_BOOT_STATUS:
               prdata_o <= {27'h0, sleep_gate_r, copy_busy_r,
                            boot_done_r, stall_r, debug_mode_vld_o};
            ADDR_IRQ_CTRL:
               prdata_o <= {30'h0, irq_ctrl_r};
            default:
               prdata_o <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------
   // Sleep control
   // ----------------------------------------
   logic [3:0] delay_cnt_r;
   logic [5:0] pending_sel_r;
   logic       pll_out_r;
   logic       pll_in_r;
   logic       wake_any;
   logic       wake_en;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         delay_cnt_r   <= 4'h0;
         pending_sel_r <= SLEEP_NONE;
      end else if (wr_en && apb_i.paddr == ADDR_CTRL_STATUS) begin
         delay_cnt_r   <= 4'(SLEEP_DELAY_CYC - 1);
         pending_sel_r <= apb_i.pwdata[SLEEP_MSB:SLEEP_LSB];
      end else if (delay_cnt_r != 4'h0) begin
         delay_cnt_r <= delay_cnt_r - 4'h1;
      end
   end

   assign wake_any = irq_s2_r[0];
   assign wake_en  = irq_s2_r[0] && irq_s2_r[1];
   assign sleep_exit = sleep_gate_r &&
      ((sleep_sel_r == SLEEP_GATE_EN && wake_en) ||
       (sleep_sel_r == SLEEP_GATE_ANY && wake_any));

   // PLL stops only clear on reset
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sleep_gate_r <= 1'b0;
         pll_out_r    <= 1'b0;
         pll_in_r     <= 1'b0;
      end else if (sleep_exit) begin
         sleep_gate_r <= 1'b0;
      end else if (delay_cnt_r == 4'h1) begin
         case (pending_sel_r)
            SLEEP_GATE_EN, SLEEP_GATE_ANY: sleep_gate_r <= 1'b1;
            SLEEP_PLL_OUT:                 pll_out_r    <= 1'b1;
            SLEEP_PLL_IN:                  pll_in_r     <= 1'b1;
            default:                       sleep_gate_r <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         resume_pulse_o <= 1'b0;
         run_isr_o      <= 1'b0;
      end else begin
         resume_pulse_o <= sleep_exit;
         run_isr_o      <= sleep_exit && wake_en
                           && irq_ctrl_r[GIE_BIT] && irq_ctrl_r[NONMASK_IRQ_ENABLE_BIT];
      end
   end

   assign cpu_clk_en_o   = !sleep_gate_r && !pll_out_r && !pll_in_r;
   assign pll_out_stop_o = pll_out_r;
   assign pll_in_stop_o  = pll_in_r;
   assign io_freeze_o    = pll_out_r || pll_in_r;

   // ----------------------------------------
   // Boot sequence
   // ----------------------------------------
   typedef enum logic [2:0] {
      BS_LOCK, BS_START, BS_HOST, BS_ROM_RD, BS_ROM_WAIT, BS_RUN
   } boot_st_t;
   boot_st_t   bst_r;
   logic [9:0] rom_ptr_r;
   logic [8:0] word_idx_r;
   logic [31:0] pack_r;
   logic [1:0] lane_r;
   logic [1:0] lanes_m1;

   always_comb begin
      case (rom_width_i)
         ROM_W8:  lanes_m1 = 2'h3;
         ROM_W16: lanes_m1 = 2'h1;
         default: lanes_m1 = 2'h0;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bst_r       <= BS_LOCK;
         stall_r     <= 1'b1;
         copy_busy_r <= 1'b0;
         boot_done_r <= 1'b0;
         rom_ptr_r   <= 10'h0;
         word_idx_r  <= 9'h0;
         pack_r      <= 32'h0;
         lane_r      <= 2'h0;
         rom_rd_o    <= '0;
         mem_wr_o    <= '0;
      end else begin
         mem_wr_o.we <= 1'b0;
         case (bst_r)
            BS_LOCK:
               if (lock_sync_r[1]) begin
                  bst_r <= BS_START;
               end
            BS_START:
               if (boot_mode_i == BOOT_ROM) begin
                  copy_busy_r <= 1'b1;
                  bst_r       <= BS_ROM_RD;
               end else begin
                  bst_r <= BS_HOST;
               end
            BS_HOST:
               if ((db_set || doorbell_r) && boot_mode_i != BOOT_ROM) begin
                  stall_r     <= 1'b0;
                  boot_done_r <= 1'b1;
                  bst_r       <= BS_RUN;
               end
            BS_ROM_RD: begin
               rom_rd_o.req  <= 1'b1;
               rom_rd_o.addr <= {22'h0, rom_ptr_r};
               bst_r         <= BS_ROM_WAIT;
            end
            BS_ROM_WAIT: begin
               rom_rd_o.req <= 1'b0;
               if (rom_rvalid_i) begin
                  case (rom_width_i)
                     ROM_W8:
                        pack_r <= {rom_rdata_i[7:0], pack_r[31:8]};
                     ROM_W16:
                        pack_r <= {rom_rdata_i[15:0], pack_r[31:16]};
                     default:
                        pack_r <= rom_rdata_i;
                  endcase
                  rom_ptr_r <= rom_ptr_r + (rom_width_i == ROM_W8 ? 10'h1 :
                               rom_width_i == ROM_W16 ? 10'h2 : 10'h4);
                  lane_r <= lane_r + 2'h1;
                  bst_r  <= BS_ROM_RD;
                  if (lane_r == lanes_m1) begin
                     lane_r        <= 2'h0;
                     mem_wr_o.we   <= 1'b1;
                     mem_wr_o.addr <= {21'h0, word_idx_r, 2'h0};
                     mem_wr_o.data <= rom_width_i == ROM_W8 ?
                        {rom_rdata_i[7:0], pack_r[31:8]} :
                        rom_width_i == ROM_W16 ?
                        {rom_rdata_i[15:0], pack_r[31:16]} : rom_rdata_i;
                     word_idx_r <= word_idx_r + 9'h1;
                     if (32'(word_idx_r) == ROM_WORDS_P - 1) begin
                        copy_busy_r <= 1'b0;
                        stall_r     <= 1'b0;
                        boot_done_r <= 1'b1;
                        bst_r       <= BS_RUN;
                     end
                  end
               end
            end
            BS_RUN:  bst_r <= BS_RUN;
            default: bst_r <= BS_LOCK;
         endcase
      end
   end

   assign cpu_stall_o = stall_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   sleep_delay_a: assert property (
      (wr_en && apb_i.paddr == ADDR_CTRL_STATUS
       && apb_i.pwdata[SLEEP_MSB:SLEEP_LSB] == SLEEP_PLL_OUT)
      |-> ##9 pll_out_stop_o)
      else $error("pll output stop not entered after nine cycles");
   pll_sticky_a: assert property (
      pll_out_stop_o |=> pll_out_stop_o)
      else $error("pll output stop left without reset");
   pll_in_sticky_a: assert property (
      pll_in_stop_o |=> pll_in_stop_o && io_freeze_o)
      else $error("pll input stop left without reset");
   freeze_out_a: assert property (
      io_freeze_o |-> !cpu_clk_en_o)
      else $error("cpu clock runs while frozen");
   gate_exit_a: assert property (
      sleep_gate_r && sleep_sel_r == SLEEP_GATE_EN && !wake_en
      |=> !resume_pulse_o)
      else $error("gate sleep left without enabled interrupt");
   isr_gate_a: assert property (
      run_isr_o |-> $past(irq_ctrl_r[GIE_BIT]) && $past(irq_ctrl_r[NONMASK_IRQ_ENABLE_BIT]))
      else $error("service run without both enables");
   stall_host_a: assert property (
      db_set && bst_r inside {BS_LOCK, BS_START, BS_ROM_RD} |=> cpu_stall_o)
      else $error("doorbell released stall outside host boot");
   doorbell_hold_a: assert property (
      doorbell_r && !db_clr |=> doorbell_r)
      else $error("doorbell dropped without clear");

   host_boot_c: cover property (bst_r == BS_HOST ##[1:50] bst_r == BS_RUN);
   rom_boot_c:  cover property (copy_busy_r ##1 !copy_busy_r);
   gate_wake_c: cover property (sleep_exit);
   pll_stop_c:  cover property (pll_out_stop_o);
endmodule : pwr_boot_ctrl

// ===== verif/boot_rom_model.sv
`timescale 1ns/1ns
module boot_rom_model (
   input  wire logic                     clk_sys_i,
   input  wire logic                     slow_i,
   input  wire pwr_boot_pkg::rom_width_t width_i,
   input  wire pwr_boot_pkg::rom_rd_t    rd_i,
   output logic                          rvalid_o,
   output logic [31:0]                   rdata_o
);
   import pwr_boot_pkg::*;

   logic [31:0] addr_r;
   int          wait_r;

   // ----------------------------------------
   // Image bytes
   // ----------------------------------------
   // Each offset has its own byte, so a skipped read shows
   function automatic logic [31:0] word(input logic [31:0] a);
      logic [31:0] w;
      for (int i = 0; i < 4; i++)
         w[8*i +: 8] = 8'(a + i) ^ 8'hA5;
      case (width_i)
         ROM_W8:  return {24'h0, w[7:0]};
         ROM_W16: return {16'h0, w[15:0]};
         default: return w;
      endcase
   endfunction : word

   initial begin
      rvalid_o = 1'b0;
      rdata_o  = 32'h0;
      addr_r   = 32'h0;
      wait_r   = 0;
   end

   // ----------------------------------------
   // Read answers
   // ----------------------------------------
   // answers in lanes of the width
   always @(posedge clk_sys_i) begin
      rvalid_o <= (rd_i.req !== 1'b1) && (wait_r == 1);
      if (rd_i.req === 1'b1) begin
         addr_r <= rd_i.addr;
         wait_r <= slow_i ? 5 : 1;
      end else if (wait_r > 0)
         wait_r <= wait_r - 1;
      // Released lanes invert so stale data cannot pass
      if (rd_i.req !== 1'b1 && wait_r == 1)
         rdata_o <= word(addr_r);
      else if (rvalid_o)
         rdata_o <= ~rdata_o;
   end
endmodule : boot_rom_model

// ===== verif/powerdown_reset_boot_control_bench.sv
`timescale 1ns/1ns
module powerdown_reset_boot_control_bench;
   import pwr_boot_pkg::*;

   typedef struct packed {
      logic [5:0] code;
      logic       ien;
      logic [1:0] ictl;
      logic [4:0] exp;
   } row_t;

   // Expected: gate, pll out, pll in, wake, service run
   localparam row_t [0:9] ROWS = {
      {SLEEP_NONE,     1'b0, 2'h0, 5'h00},
      {SLEEP_GATE_EN,  1'b1, 2'h3, 5'h13},
      {SLEEP_GATE_EN,  1'b1, 2'h1, 5'h12},
      {SLEEP_GATE_EN,  1'b0, 2'h3, 5'h10},
      {SLEEP_GATE_ANY, 1'b0, 2'h3, 5'h12},
      {SLEEP_GATE_ANY, 1'b1, 2'h3, 5'h13},
      {SLEEP_PLL_OUT,  1'b1, 2'h3, 5'h08},
      {SLEEP_PLL_IN,   1'b1, 2'h3, 5'h04},
      {6'h05,          1'b0, 2'h0, 5'h00},
      {6'h1F,          1'b1, 2'h3, 5'h00}
   };

   logic        clk_sys_i, rstn_i, trst_drv, irq_pend, irq_en, lock, slow;
   logic        pready, clk_en, pout, pin, freeze, stall, isr, resume;
   logic        dbg_vld, rvalid, perr;
   logic [1:0]  dbg_pins, dbg_mode;
   logic [31:0] prdata, rdata, first_addr;
   logic [31:0] img_q [4];
   apb_req_t    bus;
   boot_mode_t  mode;
   rom_width_t  width;
   rom_rd_t     rom_rd;
   mem_wr_t     mem_wr;
   tri0         trst_w;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          isr_cnt = 0;
   int          res_cnt = 0;
   int          wr_cnt = 0;

   // pulldown keeps test reset low when undriven
   assign trst_w = trst_drv ? 1'b1 : 1'bz;

   pwr_boot_ctrl #(.ROM_WORDS_P(4)) dut_u (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .apb_i(bus),
      .pready_o(pready), .pslverr_o(perr), .prdata_o(prdata),
      .boot_mode_i(mode), .rom_width_i(width), .trst_i(trst_w),
      .debug_config_pins_i(dbg_pins), .irq_pending_i(irq_pend),
      .irq_enabled_i(irq_en), .pll_lock_i(lock), .cpu_clk_en_o(clk_en),
      .pll_out_stop_o(pout), .pll_in_stop_o(pin), .io_freeze_o(freeze),
      .cpu_stall_o(stall), .run_isr_o(isr), .resume_pulse_o(resume),
      .debug_mode_o(dbg_mode), .debug_mode_vld_o(dbg_vld),
      .rom_rd_o(rom_rd), .rom_rvalid_i(rvalid), .rom_rdata_i(rdata),
      .mem_wr_o(mem_wr)
   );

   boot_rom_model rom_u (
      .clk_sys_i(clk_sys_i), .slow_i(slow), .width_i(width),
      .rd_i(rom_rd), .rvalid_o(rvalid), .rdata_o(rdata)
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      if (isr === 1'b1)
         isr_cnt++;
      if (resume === 1'b1)
         res_cnt++;
      if (mem_wr.we === 1'b1) begin
         if (wr_cnt == 0)
            first_addr = mem_wr.addr;
         if (wr_cnt < 4)
            img_q[wr_cnt] = mem_wr.data;
         wr_cnt++;
      end
   end

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   function automatic logic [31:0] exp_word(input int k);
      logic [31:0] w;
      for (int i = 0; i < 4; i++)
         w[8*i +: 8] = 8'(4 * k + i) ^ 8'hA5;
      return w;
   endfunction : exp_word

   // Read data is taken at the access edge where pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      bus <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk_sys_i);
      bus.penable <= 1'b1;
      @(posedge clk_sys_i);
      while (pready !== 1'b1)
         @(posedge clk_sys_i);
      q = prdata;
      check(perr, 1'b0);
      bus <= '{1'b0, 1'b0, 1'b0, 8'h00, 32'h0};
      @(posedge clk_sys_i);
   endtask : apb

   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : write_reg

   task automatic read_reg(input logic [7:0] a, output logic [31:0] q);
      apb(1'b0, a, 32'h0, q);
   endtask : read_reg

   task automatic do_reset;
      rstn_i <= 1'b0;
      // PLL must relock after every reset
      lock <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      check({stall, clk_en}, 2'h3);
      rstn_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      check(stall, 1'b1);
      lock <= 1'b1;
   endtask : do_reset

   task automatic boot_host;
      logic [31:0] q;
      repeat (12) @(posedge clk_sys_i);
      read_reg(ADDR_CTRL_STATUS, q);
      check(q[SLEEP_MSB:SLEEP_LSB], SLEEP_RST);
      check(stall, 1'b1);
      isr_cnt = 0;
      write_reg(ADDR_HOST_CTRL, 32'h2);
      repeat (2) @(posedge clk_sys_i);
      check(stall, 1'b0);
      check(isr_cnt, 0);
      read_reg(ADDR_HOST_CTRL, q);
      check(q[DOORBELL_BIT], 1'b1);
      write_reg(ADDR_CTRL_STATUS, 32'h0);
      read_reg(ADDR_HOST_CTRL, q);
      check(q[DOORBELL_BIT], 1'b0);
   endtask : boot_host

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      row_t        r;
      logic        sl;
      logic [31:0] q;
      int          n;
      rstn_i   = 1'b0;
      trst_drv = 1'b0;
      bus      = '0;
      mode     = BOOT_HOST;
      width    = ROM_W32;
      dbg_pins = 2'h0;
      irq_pend = 1'b0;
      irq_en   = 1'b0;
      lock     = 1'b0;
      slow     = 1'b0;
      do_reset();
      boot_host();
      check(dbg_vld, 1'b0);
      dbg_pins <= 2'h2;
      trst_drv <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      dbg_pins <= 2'h1;
      repeat (4) @(posedge clk_sys_i);
      check({dbg_vld, dbg_mode}, 3'h6);
      for (int i = 0; i < 10; i++) begin
         r = ROWS[i];
         sl = r.exp[4] | r.exp[3] | r.exp[2];
         write_reg(ADDR_IRQ_CTRL, {30'h0, r.ictl});
         write_reg(ADDR_CTRL_STATUS, {16'h0, r.code, 10'h000});
         repeat (10) @(posedge clk_sys_i);
         check(clk_en, !sl);
         check({pout, pin, freeze}, {r.exp[3:2], sl & ~r.exp[4]});
         if (r.exp[4]) begin
            read_reg(ADDR_BOOT_STATUS, q);
            check(q[4], 1'b1);
         end
         res_cnt = 0;
         isr_cnt = 0;
         irq_pend <= 1'b1;
         irq_en   <= r.ien;
         repeat (12) @(posedge clk_sys_i);
         check(res_cnt, r.exp[1]);
         check(isr_cnt, r.exp[0]);
         check(clk_en, !sl || r.exp[1]);
         irq_pend <= 1'b0;
         irq_en   <= 1'b0;
         if (sl & ~r.exp[1]) begin
            do_reset();
            boot_host();
         end
      end
      mode <= BOOT_EMU;
      do_reset();
      boot_host();
      mode <= BOOT_ROM;
      for (int w = 0; w < 3; w++) begin
         width  <= rom_width_t'(w);
         slow   <= (w != 0);
         wr_cnt = 0;
         do_reset();
         write_reg(ADDR_HOST_CTRL, 32'h2);
         check(stall, 1'b1);
         n = 0;
         while (stall !== 1'b0 && n < 600) begin
            @(posedge clk_sys_i);
            n++;
         end
         repeat (2) @(posedge clk_sys_i);
         check(stall, 1'b0);
         check(wr_cnt, 4);
         check(first_addr, 32'h0);
         for (int k = 0; k < 4; k++)
            check(img_q[k], exp_word(k));
      end
      results();
   end

   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      results();
   end
endmodule : powerdown_reset_boot_control_bench
